/* File: hw/urbg_defines.vh */
// Constants for the asynchronous receiver with its baud rate generator.
// Included by the receiver top module; definitions only.
`ifndef URBG_DEFINES_VH
`define URBG_DEFINES_VH

// Byte offsets of the register map
`define URBG_ADDR_MODE      8'h00
`define URBG_ADDR_STATUS    8'h04
`define URBG_ADDR_BAUD      8'h08
`define URBG_ADDR_RXBUF     8'h0c
`define URBG_ADDR_TXDATA    8'h10

// Mode register fields
`define URBG_MODE_POWER     7
`define URBG_MODE_TXE       6
`define URBG_MODE_RXE       5
`define URBG_MODE_PAR_HI    4
`define URBG_MODE_PAR_LO    3
`define URBG_MODE_CL        2
`define URBG_MODE_SL        1
`define URBG_MODE_RESET     8'h01

// Parity modes
`define URBG_PAR_NONE       2'h0
`define URBG_PAR_ZERO       2'h1
`define URBG_PAR_ODD        2'h2
`define URBG_PAR_EVEN       2'h3

// Error status fields
`define URBG_ST_PE          2
`define URBG_ST_FE          1
`define URBG_ST_OVE         0

// Baud control fields
`define URBG_BAUD_SEL_HI    7
`define URBG_BAUD_SEL_LO    6
`define URBG_BAUD_DIV_HI    4
`define URBG_BAUD_DIV_LO    0
`define URBG_BAUD_RESET     8'h1f

// Base clock select codes and prescaler masks
`define URBG_SEL_TIMER      2'h0
`define URBG_SEL_DIV2       2'h1
`define URBG_SEL_DIV8       2'h2
`define URBG_SEL_DIV32      2'h3
`define URBG_PRE_MASK2      5'h01
`define URBG_PRE_MASK8      5'h07
`define URBG_PRE_MASK32     5'h1f

// Lowest legal division value
`define URBG_DIV_MIN        5'h08

`endif

/* File: hw/urbg_rx_top.v */
// Receive path of an asynchronous serial port with its baud rate generator.
// Assumes an AHB-Lite master on hclk and an asynchronous serial line on serial_rx_line.
// Functional notes
// - Reception runs only when power bit then receive enable are set.
// - Filtered falling edge starts receive counter; resample after division value counted.
// - Low at resample point is a valid start bit; frame reception begins.
// - Data bits shift LSB first; at stop bit copy to buffer, raise interrupt.
// - On overrun the receive buffer keeps its old contents.
// - Parity mismatch does not abort; interrupt raised after frame completes.
// - Without status then buffer read, next frame overruns and error persists.
// - Exactly one stop bit checked; a second one is ignored.
// - Parity, framing and overrun errors; any set flag raises the interrupt.
// - Reading error status returns flags then clears them all.
// - Parity error when received parity disagrees with configured parity.
// - Framing error when line is not high at stop sample.
// - Overrun when a frame ends before previous buffer value was read.
// - Line sampled on base clock; filter changes only on two agreeing samples.
// - Receive processing lags the line by two base clocks.
// - Base clock reaches counters only while power bit is one.
// - Select 00 timer output, 01 divide 2, 10 divide 8, 11 divide 32.
// - Separate five-bit transmit and receive division counters.
// - Transmit counter cleared unless power and transmit enable; cleared on first write.
// - Receive counter cleared unless enabled; runs from start bit to frame end.
// - Five-bit division value k, valid from 8 to 31.
// - Bit rate equals base clock divided by two times k.
// - Power off forces line high and clears status, transmit and receive buffers.
// - Frame: start, 7 or 8 LSB-first bits, optional parity, 1-2 stops.
// - Even parity: odd ones count is error; odd parity: even count is error.
// - Zero or no parity never reports a parity error.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "urbg_defines.vh"

module urbg_rx_top
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        serial_rx_line,
    input  wire        eight_bit_timer_output,
    output reg         rx_done_or_error_irq,
    output reg         tx_baud_tick
);

    localparam ST_IDLE   = 3'h0;
    localparam ST_START  = 3'h1;
    localparam ST_DATA   = 3'h2;
    localparam ST_PARITY = 3'h3;
    localparam ST_STOP   = 3'h4;

    reg  [7:0]  async_mode_register;
    reg  [2:0]  rx_error_status_register;
    reg  [7:0]  baud_generator_control;
    reg  [7:0]  rx_buffer_register;
    reg  [7:0]  rx_shift_register;
    reg  [7:0]  tx_shift_register;
    reg         rx_full_r;
    reg         tx_started_r;

    reg         rx_meta_r;
    reg         rx_sync_r;
    reg         tm_meta_r;
    reg         tm_sync_r;
    reg         tm_prev_r;
    reg  [4:0]  pre_cnt_r;
    reg         base_tick_r;
    reg         filt_samp_r;
    reg         filt_r;
    reg         filt_prev_r;
    reg  [4:0]  rx_cnt_r;
    reg         rx_half_r;
    reg  [4:0]  tx_cnt_r;
    reg  [2:0]  state_r;
    reg  [2:0]  bit_idx_r;
    reg         par_acc_r;
    reg         par_err_r;

    reg         dph_wr_r;
    reg  [7:0]  dph_addr_r;

    wire        serial_power_on = async_mode_register[`URBG_MODE_POWER];
    wire        tx_enable_bit   = async_mode_register[`URBG_MODE_TXE];
    wire        rx_enable_bit   = async_mode_register[`URBG_MODE_RXE];
    wire [1:0]  par_mode        = async_mode_register[`URBG_MODE_PAR_HI:`URBG_MODE_PAR_LO];
    wire        eight_bits      = async_mode_register[`URBG_MODE_CL];
    wire        clock_select_high = baud_generator_control[`URBG_BAUD_SEL_HI];
    wire        clock_select_low  = baud_generator_control[`URBG_BAUD_SEL_LO];
    wire [4:0]  div_k           = baud_generator_control[`URBG_BAUD_DIV_HI:`URBG_BAUD_DIV_LO];
    wire        divider_value_msb = div_k[4];
    wire        divider_value_lsb = div_k[0];
    wire [4:0]  div_last        = (div_k < `URBG_DIV_MIN) ? (`URBG_DIV_MIN - 5'h01) : (div_k - 5'h01);
    wire        rx_run          = serial_power_on & rx_enable_bit;
    wire        tx_run          = serial_power_on & tx_enable_bit;

    wire        addr_ok   = hsel & htrans[1] & hready;
    wire        rd_status = addr_ok & ~hwrite & (haddr == `URBG_ADDR_STATUS);
    wire        rd_rxbuf  = addr_ok & ~hwrite & (haddr == `URBG_ADDR_RXBUF);
    wire        wr_mode   = dph_wr_r & (dph_addr_r == `URBG_ADDR_MODE);
    wire        wr_baud   = dph_wr_r & (dph_addr_r == `URBG_ADDR_BAUD);
    wire        wr_tx     = dph_wr_r & (dph_addr_r == `URBG_ADDR_TXDATA);

    reg         pre_hit;
    reg         half_tick;
    reg         frame_end;
    reg  [2:0]  err_new;
    reg  [31:0] rdata_nxt;

    // AHB data phase capture and zero-wait response
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h00000000;
        end
        else
        begin
            dph_wr_r   <= addr_ok & hwrite;
            dph_addr_r <= haddr;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (addr_ok & ~hwrite)
                hrdata <= rdata_nxt;
        end
    end

    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (haddr)
            `URBG_ADDR_MODE:   rdata_nxt = {24'h000000, async_mode_register};
            `URBG_ADDR_STATUS: rdata_nxt = {29'h00000000, rx_error_status_register};
            `URBG_ADDR_BAUD:   rdata_nxt = {24'h000000, clock_select_high, clock_select_low, 1'b0,
                                            divider_value_msb, div_k[3:1], divider_value_lsb};
            `URBG_ADDR_RXBUF:  rdata_nxt = {24'h000000, rx_buffer_register};
            `URBG_ADDR_TXDATA: rdata_nxt = {24'h000000, tx_shift_register};
            default:           rdata_nxt = 32'h00000000;
        endcase
    end

    // Software registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            async_mode_register    <= `URBG_MODE_RESET;
            baud_generator_control <= `URBG_BAUD_RESET;
            tx_shift_register      <= 8'h00;
            tx_started_r           <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                async_mode_register <= {hwdata[7:1], 1'b1};
            if (wr_baud)
                baud_generator_control <= {hwdata[7:6], 1'b0, hwdata[4:0]};
            if (!serial_power_on)
            begin
                tx_shift_register <= 8'h00;
                tx_started_r      <= 1'b0;
            end
            else if (wr_tx)
            begin
                tx_shift_register <= hwdata[7:0];
                tx_started_r      <= tx_enable_bit;
            end
            if (!tx_enable_bit)
                tx_started_r <= 1'b0;
        end
    end

    // Input synchronisers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            tm_meta_r <= 1'b0;
            tm_sync_r <= 1'b0;
            tm_prev_r <= 1'b0;
        end
        else
        begin
            rx_meta_r <= serial_rx_line;
            rx_sync_r <= rx_meta_r;
            tm_meta_r <= eight_bit_timer_output;
            tm_sync_r <= tm_meta_r;
            tm_prev_r <= tm_sync_r;
        end
    end

    // Base clock selection as a one-cycle tick
    always @*
    begin
        pre_hit = 1'b0;
        case ({clock_select_high, clock_select_low})
            `URBG_SEL_TIMER: pre_hit = tm_sync_r & ~tm_prev_r;
            `URBG_SEL_DIV2:  pre_hit = (pre_cnt_r & `URBG_PRE_MASK2) == `URBG_PRE_MASK2;
            `URBG_SEL_DIV8:  pre_hit = (pre_cnt_r & `URBG_PRE_MASK8) == `URBG_PRE_MASK8;
            `URBG_SEL_DIV32: pre_hit = pre_cnt_r == `URBG_PRE_MASK32;
            default:         pre_hit = 1'b0;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_cnt_r   <= 5'h00;
            base_tick_r <= 1'b0;
        end
        else if (!serial_power_on)
        begin
            pre_cnt_r   <= 5'h00;
            base_tick_r <= 1'b0;
        end
        else
        begin
            pre_cnt_r   <= pre_cnt_r + 5'h01;
            base_tick_r <= pre_hit;
        end
    end

    // Two-sample noise filter on the base clock
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filt_samp_r <= 1'b1;
            filt_r      <= 1'b1;
            filt_prev_r <= 1'b1;
        end
        else if (!serial_power_on)
        begin
            filt_samp_r <= 1'b1;
            filt_r      <= 1'b1;
            filt_prev_r <= 1'b1;
        end
        else if (base_tick_r)
        begin
            filt_samp_r <= rx_sync_r;
            if (filt_samp_r == rx_sync_r)
                filt_r <= rx_sync_r;
            filt_prev_r <= filt_r;
        end
    end

    // Transmit division counter
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_cnt_r     <= 5'h00;
            tx_baud_tick <= 1'b0;
        end
        else if (!tx_run || (wr_tx && !tx_started_r))
        begin
            tx_cnt_r     <= 5'h00;
            tx_baud_tick <= 1'b0;
        end
        else if (base_tick_r)
        begin
            tx_baud_tick <= tx_cnt_r == div_last;
            tx_cnt_r     <= (tx_cnt_r == div_last) ? 5'h00 : tx_cnt_r + 5'h01;
        end
        else
            tx_baud_tick <= 1'b0;
    end

    // Receive half-bit tick: every k base clocks while a frame runs
    always @*
    begin
        half_tick = base_tick_r & (state_r != ST_IDLE) & (rx_cnt_r == div_last);
    end

    wire        bit_tick = half_tick & rx_half_r;
    wire        par_bad  = (par_mode == `URBG_PAR_EVEN) ? (par_acc_r ^ filt_r) : ~(par_acc_r ^ filt_r);

    always @*
    begin
        frame_end = (state_r == ST_STOP) & bit_tick;
        err_new   = 3'h0;
        err_new[`URBG_ST_FE]  = ~filt_r;
        err_new[`URBG_ST_OVE] = rx_full_r;
        err_new[`URBG_ST_PE]  = par_err_r;
    end

    // Receive frame sequencer and division counter
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r           <= ST_IDLE;
            rx_cnt_r          <= 5'h00;
            rx_half_r         <= 1'b0;
            bit_idx_r         <= 3'h0;
            par_acc_r         <= 1'b0;
            par_err_r         <= 1'b0;
            rx_shift_register <= 8'h00;
        end
        else if (!rx_run)
        begin
            state_r   <= ST_IDLE;
            rx_cnt_r  <= 5'h00;
            rx_half_r <= 1'b0;
        end
        else
        begin
            if (base_tick_r && state_r != ST_IDLE)
                rx_cnt_r <= (rx_cnt_r == div_last) ? 5'h00 : rx_cnt_r + 5'h01;
            if (half_tick)
                rx_half_r <= ~rx_half_r;
            case (state_r)
                ST_IDLE:
                begin
                    rx_cnt_r  <= 5'h00;
                    rx_half_r <= 1'b0;
                    if (base_tick_r && filt_prev_r && !filt_r)
                        state_r <= ST_START;
                end
                ST_START:
                begin
                    if (half_tick)
                    begin
                        if (filt_r)
                            state_r <= ST_IDLE;
                        else
                        begin
                            state_r   <= ST_DATA;
                            rx_half_r <= 1'b0;
                            bit_idx_r <= 3'h0;
                            par_acc_r <= 1'b0;
                            par_err_r <= 1'b0;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (bit_tick)
                    begin
                        rx_shift_register <= eight_bits ? {filt_r, rx_shift_register[7:1]}
                                                        : {1'b0, filt_r, rx_shift_register[6:1]};
                        par_acc_r <= par_acc_r ^ filt_r;
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == (eight_bits ? 3'h7 : 3'h6))
                            state_r <= (par_mode == `URBG_PAR_NONE) ? ST_STOP : ST_PARITY;
                    end
                end
                ST_PARITY:
                begin
                    if (bit_tick)
                    begin
                        par_err_r <= par_mode[1] & par_bad;
                        state_r   <= ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    if (bit_tick)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Receive buffer, error status and interrupt
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_buffer_register       <= 8'h00;
            rx_full_r                <= 1'b0;
            rx_error_status_register <= 3'h0;
            rx_done_or_error_irq     <= 1'b0;
        end
        else if (!serial_power_on)
        begin
            rx_buffer_register       <= 8'h00;
            rx_full_r                <= 1'b0;
            rx_error_status_register <= 3'h0;
            rx_done_or_error_irq     <= 1'b0;
        end
        else
        begin
            rx_done_or_error_irq <= frame_end;
            if (frame_end)
            begin
                if (!rx_full_r)
                    rx_buffer_register <= rx_shift_register;
                rx_full_r <= 1'b1;
            end
            else if (rd_rxbuf)
                rx_full_r <= 1'b0;
            if (frame_end && rd_status)
                rx_error_status_register <= err_new;
            else if (frame_end)
                rx_error_status_register <= rx_error_status_register | err_new;
            else if (rd_status)
                rx_error_status_register <= 3'h0;
        end
    end

endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the receiver top with a remote serial source.
// Assumes the design under hw/ and the source model beside this file.
`timescale 1ns/1ps
`include "urbg_defines.vh"
module tb_top;
    reg         hclk;
    reg         hresetn;
    reg         hsel;
    reg  [7:0]  haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [31:0] hwdata;
    reg         go;
    reg  [11:0] frame;
    reg  [3:0]  nbits;
    reg  [7:0]  per;
    reg         tmr_r = 1'b0;
    reg  [1:0]  tmr_cnt_r = 2'h0;
    reg  [31:0] rd;
    reg         got;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        hresp;
    wire        rx_line;
    wire        busy;
    wire        irq;
    wire        tick;
    integer     err_total;
    integer     cmp_count;

    urbg_rx_top urbg_rx_top_i
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .serial_rx_line(rx_line), .eight_bit_timer_output(tmr_r),
        .rx_done_or_error_irq(irq), .tx_baud_tick(tick)
    );
    urbg_ser_src urbg_ser_src_i
    (
        .hclk(hclk), .go(go), .frame(frame), .nbits(nbits), .per(per), .line(rx_line), .busy(busy)
    );

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Timer output with a rising edge every 8 hclk
    always @(posedge hclk)
    begin
        tmr_cnt_r <= tmr_cnt_r + 2'h1;
        if (tmr_cnt_r == 2'h3)
            tmr_r <= ~tmr_r;
    end

    task summarize;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    task chk(input [31:0] g, input [31:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            err_total = err_total + 1;
        end
    end
    endtask

    task ready_wait;
        integer n;
    begin
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n = n + 1;
            if (n > 16)
            begin
                err_total = err_total + 1;
                summarize;
            end
            @(posedge hclk);
        end
    end
    endtask

    task bus(input [7:0] a, input w, input [31:0] wd);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        ready_wait;
        htrans <= 2'h0;
        hwdata <= wd;
        ready_wait;
        rd = hrdata;
    end
    endtask

    task rd_reg(input [7:0] a, input [7:0] e);
    begin
        bus(a, 1'b0, 32'h0);
        chk(rd, {24'h0, e});
    end
    endtask

    // Looks for a pulse on tick (sel high) or on the frame-end output
    task wait_ev(input sel, input integer lim);
        integer i;
    begin
        got = 1'b0;
        for (i = 0; i < lim && !got; i = i + 1)
        begin
            @(posedge hclk);
            got = sel ? (tick === 1'b1) : (irq === 1'b1);
        end
    end
    endtask

    task launch(input [11:0] f, input [3:0] n, input [7:0] p);
    begin
        frame <= f;
        nbits <= n;
        per <= p;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
    end
    endtask

    // One frame at 32 hclk a bit, parity from the mode, then one idle bit
    task xfer(input [7:0] m, input [7:0] d, input flip, input stopv);
        integer i;
        reg [11:0] f;
    begin
        bus(`URBG_ADDR_MODE, 1'b1, {24'h0, m});
        f = 12'hfff;
        f[0] = 1'b0;
        for (i = 0; i < (m[2] ? 8 : 7); i = i + 1)
            f[i + 1] = d[i];
        if (m[4:3] != 2'h0)
        begin
            f[i + 1] = (m[4] ? (^d ^ !m[3]) : 1'b0) ^ flip;
            i = i + 1;
        end
        f[i + 1] = stopv;
        launch(f, i + 3, 8'd32);
        wait_ev(1'b0, 600);
        chk(got, 1'b1);
        for (i = 0; i < 200 && busy; i = i + 1)
            @(posedge hclk);
        chk(busy, 1'b0);
    end
    endtask

    task one_frame(input [7:0] m, input [7:0] d, input flip, input stopv, input [7:0] est, input [7:0] eb);
    begin
        xfer(m, d, flip, stopv);
        rd_reg(`URBG_ADDR_STATUS, est);
        rd_reg(`URBG_ADDR_STATUS, 8'h00);
        rd_reg(`URBG_ADDR_RXBUF, eb);
    end
    endtask

    task glitch(input [7:0] p);
    begin
        launch(12'h000, 4'h1, p);
        wait_ev(1'b0, 300);
        chk(got, 1'b0);
    end
    endtask

    task clk_case(input [1:0] s, input [4:0] k, input [31:0] e);
        integer i;
        integer n;
    begin
        bus(`URBG_ADDR_BAUD, 1'b1, {24'h0, s, 1'b0, k});
        for (i = 0; i < 3; i = i + 1)
        begin
            n = 0;
            @(posedge hclk);
            while (tick !== 1'b1 && n < 1000)
            begin
                @(posedge hclk);
                n = n + 1;
            end
        end
        chk(n + 1, e);
    end
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        go = 1'b0;
        frame = 12'hfff;
        nbits = 4'h1;
        per = 8'h01;
        err_total = 0;
        cmp_count = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd_reg(`URBG_ADDR_MODE, `URBG_MODE_RESET);
        rd_reg(`URBG_ADDR_STATUS, 8'h00);
        rd_reg(`URBG_ADDR_BAUD, `URBG_BAUD_RESET);
        rd_reg(8'h14, 8'h00);
        bus(`URBG_ADDR_STATUS, 1'b1, 32'hff);
        rd_reg(`URBG_ADDR_STATUS, 8'h00);
        bus(`URBG_ADDR_BAUD, 1'b1, 32'h68);
        rd_reg(`URBG_ADDR_BAUD, 8'h48);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h80);
        $display("test registers done");
        one_frame(8'ha6, 8'h55, 1'b0, 1'b1, 8'h00, 8'h55);
        one_frame(8'hbc, 8'h55, 1'b0, 1'b1, 8'h00, 8'h55);
        one_frame(8'hbc, 8'h55, 1'b1, 1'b1, 8'h04, 8'h55);
        one_frame(8'hb4, 8'h87, 1'b0, 1'b1, 8'h00, 8'h87);
        one_frame(8'hb4, 8'h87, 1'b1, 1'b1, 8'h04, 8'h87);
        one_frame(8'hac, 8'h87, 1'b1, 1'b1, 8'h00, 8'h87);
        one_frame(8'ha4, 8'h3c, 1'b0, 1'b0, 8'h02, 8'h3c);
        one_frame(8'hb0, 8'h36, 1'b0, 1'b1, 8'h00, 8'h36);
        $display("test frames done");
        glitch(8'd6);
        glitch(8'd1);
        one_frame(8'ha4, 8'h5a, 1'b0, 1'b1, 8'h00, 8'h5a);
        xfer(8'ha4, 8'h11, 1'b0, 1'b1);
        one_frame(8'ha4, 8'h22, 1'b0, 1'b1, 8'h01, 8'h11);
        one_frame(8'ha4, 8'h33, 1'b0, 1'b1, 8'h00, 8'h33);
        $display("test start and overrun done");
        bus(`URBG_ADDR_MODE, 1'b1, 32'hc0);
        clk_case(2'h1, 5'd31, 62);
        clk_case(2'h2, 5'd8, 64);
        clk_case(2'h3, 5'd8, 256);
        clk_case(2'h0, 5'd10, 80);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h80);
        repeat (2) @(posedge hclk);
        wait_ev(1'b1, 400);
        chk(got, 1'b0);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h40);
        wait_ev(1'b1, 400);
        chk(got, 1'b0);
        $display("test base clock done");
        bus(`URBG_ADDR_BAUD, 1'b1, 32'h48);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h80);
        xfer(8'ha4, 8'h77, 1'b0, 1'b0);
        bus(`URBG_ADDR_TXDATA, 1'b1, 32'ha5);
        rd_reg(`URBG_ADDR_TXDATA, 8'ha5);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h00);
        bus(`URBG_ADDR_MODE, 1'b1, 32'h80);
        rd_reg(`URBG_ADDR_TXDATA, 8'h00);
        rd_reg(`URBG_ADDR_STATUS, 8'h00);
        rd_reg(`URBG_ADDR_RXBUF, 8'h00);
        $display("test power off done");
        summarize;
    end
endmodule

/* File: test/urbg_rx_props.sv */
// Checker for the receiver top: bus answer, pulse spacing, read-clear, enables.
// Sees only the top module's ports; attached by the bind below.
`timescale 1ns/1ps
`include "urbg_defines.vh"
module urbg_rx_props
(
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        serial_rx_line,
    input wire        eight_bit_timer_output,
    input wire        rx_done_or_error_irq,
    input wire        tx_baud_tick
);
    reg       wr_ph_r;
    reg [7:0] mode_r;
    reg       clean_r;
    wire      taken = hsel && htrans[1] && hready;
    wire      st_rd = taken && !hwrite && haddr == `URBG_ADDR_STATUS;
    wire      rx_on = mode_r[7] && mode_r[5];
    wire      tx_on = mode_r[7] && mode_r[6];

    // Shadow of the mode register and a no-frame-since-status-read flag
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_r <= 1'b0;
            mode_r  <= `URBG_MODE_RESET;
            clean_r <= 1'b0;
        end
        else
        begin
            wr_ph_r <= taken && hwrite && haddr == `URBG_ADDR_MODE;
            if (wr_ph_r)
                mode_r <= hwdata[7:0];
            if (rx_done_or_error_irq)
                clean_r <= 1'b0;
            else if (st_rd)
                clean_r <= 1'b1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state inserted");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    a_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
    a_status_clear: assert property (st_rd && clean_r && !rx_done_or_error_irq |=> hrdata[2:0] == 3'h0)
        else $error("status not cleared by read");
    a_irq_gap: assert property (rx_done_or_error_irq |=> !rx_done_or_error_irq [*8])
        else $error("frame end pulse too long");
    a_tick_gap: assert property (tx_baud_tick |=> !tx_baud_tick [*8])
        else $error("tick spacing too short");
    a_irq_needs_rx: assert property (rx_done_or_error_irq |-> rx_on || $past(rx_on))
        else $error("frame end while receiver off");
    a_tick_needs_tx: assert property (tx_baud_tick |-> tx_on || $past(tx_on))
        else $error("tick while transmitter off");
endmodule

bind urbg_rx_top urbg_rx_props urbg_rx_props_i
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serial_rx_line(serial_rx_line), .eight_bit_timer_output(eight_bit_timer_output),
    .rx_done_or_error_irq(rx_done_or_error_irq), .tx_baud_tick(tx_baud_tick)
);

/* File: test/urbg_ser_src.sv */
// Remote serial transmitter: sends nbits of frame, bit 0 first, per hclk each.
// Assumes go is raised for one hclk while busy is low; line idles high.
`timescale 1ns/1ps
module urbg_ser_src
(
    input wire        hclk,
    input wire        go,
    input wire [11:0] frame,
    input wire [3:0]  nbits,
    input wire [7:0]  per,
    output reg        line = 1'b1,
    output reg        busy = 1'b0
);
    reg [11:0] sh_r;
    reg [3:0]  left_r;
    reg [7:0]  cnt_r;

    always @(posedge hclk)
    begin
        if (!busy && go)
        begin
            line   <= frame[0];
            sh_r   <= frame >> 1;
            left_r <= nbits - 4'h1;
            cnt_r  <= per - 8'h01;
            busy   <= 1'b1;
        end
        else if (busy && cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        else if (busy)
        begin
            line   <= (left_r == 4'h0) ? 1'b1 : sh_r[0];
            sh_r   <= sh_r >> 1;
            left_r <= left_r - 4'h1;
            cnt_r  <= per - 8'h01;
            busy   <= left_r != 4'h0;
        end
    end
endmodule
